/* hdl/dac_ctl_defs.svh */
// constants of the converter clear and fault control block
`ifndef DAC_CTL_DEFS_SVH
`define DAC_CTL_DEFS_SVH

`define ADDR_W        10
`define IDX_DATA      8'h01
`define IDX_CTRL      8'h55
`define IDX_RESET     8'h56
`define IDX_STATUS    8'h57

`define CTRL_CLR_VAL  15
`define CTRL_STRETCH  14
`define CTRL_OUTRES   13
`define CTRL_OUT_ON   12
`define CTRL_RANGE_HI 2
`define CTRL_RANGE_LO 0
`define RESET_BIT     0
`define STAT_IOUT     2
`define STAT_OTEMP    0

`define CTRL_RESET_VAL 16'h0000
`define DATA_RESET_VAL 16'h0000
`define CODE_ZERO      16'h0000
`define CODE_MID       16'h8000
`define RANGE_V_LAST   3'h3
`define RANGE_I_FIRST  3'h5
`define RANGE_BIP_BIT  1

`endif

/* hdl/dac_ctl_pkg.sv */
// types of the converter clear and fault control block
package dac_ctl_pkg;
  typedef enum logic [2:0] {
    out_live     = 3'b001,
    out_clearing = 3'b010,
    out_held     = 3'b100
  } out_state_type;
endpackage

/* hdl/code_pick.sv */
// output code register choosing live data or the default value
`include "dac_ctl_defs.svh"
module code_pick
  import dac_ctl_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire out_state_type state,
  input  wire logic [15:0]   data_code,
  input  wire logic [2:0]    range_code,
  input  wire logic          sel_eff,
  output wire logic [15:0]   dflt_code,
  output logic      [15:0]   out_code
);
  wire logic is_current;
  wire logic is_bipolar;
  wire logic [15:0] next_code;

  assign is_current = (range_code >= `RANGE_I_FIRST);
  assign is_bipolar = !is_current && range_code[`RANGE_BIP_BIT];
  // current ranges sit at their bottom; voltage follows the selection
  assign dflt_code  = is_current ? `CODE_ZERO :
                      (is_bipolar ^ sel_eff) ? `CODE_MID : `CODE_ZERO;
  assign next_code  = (state == out_live) ? data_code : dflt_code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_code <= `CODE_ZERO;
    end else begin
      out_code <= next_code;
    end
  end
endmodule // code_pick

/* hdl/dac_ctl.sv */
// register slave, clear sequencing and fault reporting of the converter
`include "dac_ctl_defs.svh"
module dac_ctl
  import dac_ctl_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output wire logic                pready,
  output wire logic                pslverr,
  input  wire logic                clear,
  input  wire logic                clear_select,
  input  wire logic                latch_n,
  input  wire logic                headroom_low,
  input  wire logic                core_hot,
  output wire logic                fault_n_out,
  output logic                     fault_oe_n,
  output wire logic [15:0]         out_code,
  output logic                     voltage_on,
  output logic                     current_on,
  output logic                     range_stretch,
  output logic                     outside_resistor
);
  out_state_type state;
  out_state_type next_state;
  logic [15:0]   ctrl;
  logic [15:0]   input_code;
  logic [15:0]   data_code;
  logic          pending;
  logic          latch_prev;
  logic          stat_iout;
  logic          stat_otemp;

  wire logic        setup_rd;
  wire logic        access;
  wire logic        aligned;
  wire logic        hit_data;
  wire logic        hit_ctrl;
  wire logic        hit_reset;
  wire logic        hit_stat;
  wire logic        mapped;
  wire logic        wr_data;
  wire logic        wr_ctrl;
  wire logic        soft_rst;
  wire logic        data_ok;
  wire logic        latch_rise;
  wire logic        sel_eff;
  wire logic        clear_value_bit;
  wire logic        output_on_bit;
  wire logic [2:0]  range_code;
  wire logic [2:0]  new_range;
  wire logic        new_is_voltage;
  wire logic        range_change;
  wire logic        out_on_rise;
  wire logic        go_default;
  wire logic        is_voltage;
  wire logic        is_current;
  wire logic [15:0] dflt_code;
  wire logic [31:0] rd_word;

  // register bus decode; zero wait states
  assign pready   = 1'b1;
  assign setup_rd = psel && !penable && !pwrite;
  assign access   = psel && penable;
  assign aligned  = (paddr[1:0] == 2'b00);
  assign hit_data  = aligned && (paddr[`ADDR_W-1:2] == `IDX_DATA);
  assign hit_ctrl  = aligned && (paddr[`ADDR_W-1:2] == `IDX_CTRL);
  assign hit_reset = aligned && (paddr[`ADDR_W-1:2] == `IDX_RESET);
  assign hit_stat  = aligned && (paddr[`ADDR_W-1:2] == `IDX_STATUS);
  assign mapped   = hit_data || hit_ctrl || hit_reset || hit_stat;
  assign pslverr  = access && !mapped;
  assign wr_data  = access && pwrite && hit_data;
  assign wr_ctrl  = access && pwrite && hit_ctrl;
  assign soft_rst = access && pwrite && hit_reset && pwdata[`RESET_BIT];

  // status writes fall through: nothing is stored for them
  assign rd_word = hit_data ? {16'h0000, input_code} :
                   hit_ctrl ? {16'h0000, ctrl} :
                   hit_stat ? {29'h0000000, stat_iout, 1'b0, stat_otemp} :
                   32'h00000000;

  // control fields
  assign clear_value_bit = ctrl[`CTRL_CLR_VAL];
  assign output_on_bit   = ctrl[`CTRL_OUT_ON];
  assign range_code      = ctrl[`CTRL_RANGE_HI:`CTRL_RANGE_LO];
  assign sel_eff         = clear_select || clear_value_bit;
  assign new_range       = pwdata[`CTRL_RANGE_HI:`CTRL_RANGE_LO];
  assign new_is_voltage  = (new_range <= `RANGE_V_LAST);
  assign is_voltage      = (range_code <= `RANGE_V_LAST);
  assign is_current      = (range_code >= `RANGE_I_FIRST);
  assign range_change    = wr_ctrl && new_is_voltage && (new_range != range_code);
  assign out_on_rise     = wr_ctrl && pwdata[`CTRL_OUT_ON] && !output_on_bit;
  assign go_default      = !clear && (range_change || out_on_rise);

  // new data only while clear is low
  assign data_ok    = wr_data && !clear;
  assign latch_rise = latch_n && !latch_prev;

  always_comb begin
    next_state = state;
    unique case (state)
      out_live: begin
        if (clear) begin
          next_state = out_clearing;
        end else if (go_default) begin
          next_state = out_held;
        end
      end
      out_clearing: begin
        if (!clear) begin
          next_state = out_held;
        end
      end
      out_held: begin
        if (clear) begin
          next_state = out_clearing;
        end else if (latch_rise) begin
          next_state = out_live;
        end
      end
      default: begin
        next_state = out_held;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= out_held;
    end else if (soft_rst) begin
      state <= out_held;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET_VAL;
    end else if (soft_rst) begin
      ctrl <= `CTRL_RESET_VAL;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_code <= `DATA_RESET_VAL;
    end else if (soft_rst) begin
      input_code <= `DATA_RESET_VAL;
    end else if (data_ok) begin
      input_code <= pwdata[15:0];
    end
  end

  // a latch pulse with no fresh data keeps data_code: the pre-clear code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_code <= `DATA_RESET_VAL;
      pending   <= 1'b0;
    end else if (soft_rst) begin
      data_code <= `DATA_RESET_VAL;
      pending   <= 1'b0;
    end else begin
      if (latch_rise && pending && !clear) begin
        data_code <= input_code;
      end
      pending <= data_ok || (pending && !(latch_rise && !clear));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_prev <= 1'b1;
    end else begin
      latch_prev <= latch_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= rd_word;
    end
  end

  // fault and status follow their conditions
  assign fault_n_out = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_oe_n <= 1'b1;
      stat_iout  <= 1'b0;
      stat_otemp <= 1'b0;
    end else begin
      fault_oe_n <= !(headroom_low || core_hot);
      stat_iout  <= headroom_low;
      stat_otemp <= core_hot;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_on       <= 1'b0;
      current_on       <= 1'b0;
      range_stretch    <= 1'b0;
      outside_resistor <= 1'b0;
    end else begin
      voltage_on       <= output_on_bit && is_voltage;
      current_on       <= output_on_bit && is_current;
      range_stretch    <= ctrl[`CTRL_STRETCH] && is_voltage;
      outside_resistor <= ctrl[`CTRL_OUTRES];
    end
  end

  code_pick u_code_pick (
    .pclk       (pclk),
    .presetn    (presetn),
    .state      (state),
    .data_code  (data_code),
    .range_code (range_code),
    .sel_eff    (sel_eff),
    .dflt_code  (dflt_code),
    .out_code   (out_code)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fault_headroom;
    headroom_low |=> !fault_oe_n && stat_iout;
  endproperty
  a_fault_headroom: assert property (p_fault_headroom) else $error("headroom fault not raised");

  property p_fault_hot;
    core_hot |=> !fault_oe_n && stat_otemp;
  endproperty
  a_fault_hot: assert property (p_fault_hot) else $error("temperature fault not raised");

  property p_status_which;
    (headroom_low && !core_hot) |=> stat_iout && !stat_otemp;
  endproperty
  a_status_which: assert property (p_status_which) else $error("status source wrong");

  property p_fault_release;
    (!headroom_low && !core_hot) |=> fault_oe_n && !stat_iout && !stat_otemp;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("fault held without cause");

  property p_clear_value;
    (clear && !soft_rst) |=> (state == out_clearing) ##1 (out_code == $past(dflt_code));
  endproperty
  a_clear_value: assert property (p_clear_value) else $error("clear value not driven");

  property p_clear_select_or;
    (state == out_clearing && clear_select && is_voltage && range_code[`RANGE_BIP_BIT]) |=> out_code == `CODE_ZERO;
  endproperty
  a_clear_select_or: assert property (p_clear_select_or) else $error("select pin ignored");

  property p_clear_current;
    (state == out_clearing && is_current) |=> out_code == `CODE_ZERO;
  endproperty
  a_clear_current: assert property (p_clear_current) else $error("current not at bottom");

  property p_stay_cleared;
    (state == out_clearing && !clear && !soft_rst) ##1 (!latch_rise && !clear)[*2] |-> state == out_held;
  endproperty
  a_stay_cleared: assert property (p_stay_cleared) else $error("left cleared value");

  property p_restore;
    (state == out_held && latch_rise && !clear && !pending && !soft_rst)
      |=> (state == out_live) ##1 (out_code == $past(data_code, 2));
  endproperty
  a_restore: assert property (p_restore) else $error("pre-clear code not restored");

  property p_clear_blocks_data;
    clear |=> input_code == $past(input_code);
  endproperty
  a_clear_blocks_data: assert property (p_clear_blocks_data) else $error("data taken during clear");

  property p_range_default;
    (go_default && !soft_rst && state != out_clearing) |=> state == out_held ##1 out_code == $past(dflt_code);
  endproperty
  a_range_default: assert property (p_range_default) else $error("default not applied");

  property p_out_on_default;
    (out_on_rise && !clear && !soft_rst) |=> state == out_held && output_on_bit;
  endproperty
  a_out_on_default: assert property (p_out_on_default) else $error("enable did not go default");

  property p_ctrl_fields;
    (wr_ctrl && !soft_rst) |=> ##1 outside_resistor == $past(pwdata[`CTRL_OUTRES], 2)
      && voltage_on == ($past(pwdata[`CTRL_OUT_ON], 2) && ($past(new_range, 2) <= `RANGE_V_LAST));
  endproperty
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields not applied");

  c_clear_restore: cover property (clear ##1 !clear [*2] ##[1:20] (state == out_live));
  c_range_change: cover property (range_change ##1 state == out_held);
  c_fault: cover property (core_hot ##1 !fault_oe_n);
endmodule // dac_ctl

/* test/host_pins.sv */
// host model driving the clear, clear select and latch pins
module host_pins (
  input  wire logic pclk,
  output logic      clear,
  output logic      clear_select,
  output logic      latch_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    clear        = 1'b0;
    clear_select = 1'b0;
    latch_n      = 1'b1;
  end

  // the caller writes new data both while clear is low and while clear is still high
  task automatic pins(input logic c, input logic s);
    @(posedge pclk);
    clear        <= c;
    clear_select <= s;
  endtask

  // one low cycle with no data shifted in
  task automatic strobe();
    @(posedge pclk);
    latch_n <= 1'b0;
    @(posedge pclk);
    latch_n <= 1'b1;
  endtask
endmodule // host_pins

/* test/tb_top.sv */
// testbench of the converter clear and fault control block
`include "dac_ctl_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                pclk, presetn, psel, penable, pwrite, headroom_low, core_hot, err;
  logic [`ADDR_W-1:0]  paddr;
  logic [31:0]         pwdata, rd;
  wire logic [31:0]    prdata;
  wire logic [15:0]    out_code;
  wire logic           pready, pslverr, clear, clear_select, latch_n, fault_n_out, fault_oe_n;
  wire logic           voltage_on, current_on, range_stretch, outside_resistor, fault_pin;
  int                  errors, num_checks;
  logic [2:0]          t_rng [6] = '{3'b000, 3'b000, 3'b010, 3'b010, 3'b101, 3'b110};
  logic                t_sel [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic                t_pin [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0]         t_exp [6] = '{16'h0000, 16'h8000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};

  // pull-up on the shared fault line
  assign fault_pin = fault_oe_n ? 1'b1 : fault_n_out;

  dac_ctl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear(clear), .clear_select(clear_select), .latch_n(latch_n), .headroom_low(headroom_low),
    .core_hot(core_hot), .fault_n_out(fault_n_out), .fault_oe_n(fault_oe_n), .out_code(out_code),
    .voltage_on(voltage_on), .current_on(current_on), .range_stretch(range_stretch),
    .outside_resistor(outside_resistor));

  host_pins host_u (.pclk(pclk), .clear(clear), .clear_select(clear_select), .latch_n(latch_n));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask

  task automatic ochk(input string name, input logic [15:0] exp);
    chk(name, {16'h0000, exp}, {16'h0000, out_code});
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [31:0] ctl(input logic s, input logic st, input logic x, input logic on,
                                      input logic [2:0] r);
    return {16'h0000, s, st, x, on, 9'h000, r};
  endfunction

  initial begin
    #50000;
    errors++;
    results();
  end

  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = '0;
    pwdata       = '0;
    headroom_low = 1'b0;
    core_hot     = 1'b0;
    errors       = 0;
    num_checks   = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    ochk("out_code", 16'h0000);
    chk("fault_pin", 32'h1, 32'(fault_pin));
    rchk("status", 10'h15c, 32'h0);
    $display("test reset done");
    headroom_low <= 1'b1;
    settle();
    chk("fault_pin", 32'h0, 32'(fault_pin));
    rchk("status", 10'h15c, 32'h4);
    core_hot     <= 1'b1;
    headroom_low <= 1'b0;
    settle();
    chk("fault_pin", 32'h0, 32'(fault_pin));
    rchk("status", 10'h15c, 32'h1);
    apb(1'b1, 10'h15c, 32'h0000_ffff);
    rchk("status", 10'h15c, 32'h1);
    core_hot <= 1'b0;
    settle();
    chk("fault_pin", 32'h1, 32'(fault_pin));
    rchk("status", 10'h15c, 32'h0);
    $display("test fault done");
    apb(1'b0, 10'h200, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    chk("prdata", 32'h0, rd);
    apb(1'b0, 10'h156, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    apb(1'b0, 10'h15c, 32'h0);
    chk("pslverr", 32'h0, 32'(err));
    $display("test bus done");
    apb(1'b1, 10'h154, ctl(1'b0, 1'b1, 1'b1, 1'b1, 3'b001));
    settle();
    chk("enables", 32'hb, 32'({voltage_on, current_on, range_stretch, outside_resistor}));
    apb(1'b1, 10'h154, ctl(1'b0, 1'b1, 1'b0, 1'b1, 3'b101));
    settle();
    chk("enables", 32'h4, 32'({voltage_on, current_on, range_stretch, outside_resistor}));
    apb(1'b1, 10'h154, ctl(1'b0, 1'b0, 1'b1, 1'b1, 3'b100));
    settle();
    chk("enables", 32'h1, 32'({voltage_on, current_on, range_stretch, outside_resistor}));
    $display("test control done");
    for (int i = 0; i < 6; i++) begin
      host_u.pins(1'b0, t_pin[i] & t_sel[i]);
      apb(1'b1, 10'h154, ctl(t_sel[i] & ~t_pin[i], 1'b0, 1'b0, 1'b0, t_rng[i]));
      apb(1'b1, 10'h154, ctl(t_sel[i] & ~t_pin[i], 1'b0, 1'b0, 1'b1, t_rng[i]));
      settle();
      ochk("default", t_exp[i]);
      apb(1'b1, 10'h004, 32'h0000_1234);
      host_u.strobe();
      settle();
      ochk("data", 16'h1234);
      host_u.pins(1'b1, t_pin[i] & t_sel[i]);
      settle();
      ochk("cleared", t_exp[i]);
      apb(1'b1, 10'h004, 32'h0000_5678);
      host_u.pins(1'b0, t_pin[i] & t_sel[i]);
      settle();
      ochk("held", t_exp[i]);
      host_u.strobe();
      settle();
      ochk("restored", 16'h1234);
    end
    $display("test clear done");
    host_u.pins(1'b0, 1'b0);
    apb(1'b1, 10'h154, ctl(1'b0, 1'b0, 1'b0, 1'b1, 3'b010));
    settle();
    ochk("range", 16'h8000);
    apb(1'b1, 10'h154, ctl(1'b1, 1'b0, 1'b0, 1'b1, 3'b011));
    settle();
    ochk("range", 16'h0000);
    $display("test range done");
    apb(1'b1, 10'h158, 32'h0000_0001);
    settle();
    chk("soft_reset", 32'h0, 32'({voltage_on, out_code}));
    $display("test soft reset done");
    results();
  end
endmodule // tb_top
